/* flash_cui_host.v */
// host-side controller for a byte-wide flash with a command user interface.
// software orders operations over avalon-mm; the block drives the flash pins and polls status.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cui_regs.vh"

// How it works
// - read array, identifier and status modes each start with one command write.
// - byte program writes 40H or 10H, then data at the target address.
// - block erase writes 20H, then D0H at the block address.
// - if suspend did not take, resume is sent only after the next erase.
// - protect set is 57H then D0H at the protect address; loads lock bits.
// - block lock is preceded by protect reset; 77H then D0H at block.
// - after block lock, protect set is issued so the new lock applies.
// - two-byte program: FBH, first byte, then second byte at target.
// - poll steps read result bits only once bit 7 shows ready; read status loads them from a single read.
module flash_cui_host #(
    parameter AW = 19
) (
    input  wire          i_clk,
    input  wire          i_arst_n,
    input  wire          i_en,
    input  wire [4:0]    i_address,
    input  wire          i_read,
    input  wire          i_write,
    input  wire [31:0]   i_writedata,
    input  wire [3:0]    i_byteenable,
    output reg  [31:0]   o_readdata,
    output reg           o_waitrequest,
    output wire [AW-1:0] o_flash_addr,
    output wire [7:0]    o_flash_dq_out,
    output wire          o_flash_dq_oe,
    input  wire [7:0]    i_flash_dq_in,
    output wire          o_flash_ce_n,
    output wire          o_flash_oe_n,
    output wire          o_flash_we_n,
    output reg           o_power_down_pin_n,
    input  wire          i_ready_busy_pin
);

localparam [1:0] S_IDLE  = 2'h0;
localparam [1:0] S_ISSUE = 2'h1;
localparam [1:0] S_WAIT  = 2'h2;

// step entry: kind, condition, address select, data select, literal
localparam [1:0] K_WR   = 2'h0;
localparam [1:0] K_RD   = 2'h1;
localparam [1:0] K_POLL = 2'h2;
localparam [1:0] K_END  = 2'h3;
localparam [1:0] C_ALL  = 2'h0;
localparam [1:0] C_DEF  = 2'h1;
localparam [1:0] C_NDEF = 2'h2;
localparam       A_REG  = 1'b0;
localparam       A_PROT = 1'b1;
localparam [1:0] D_LIT  = 2'h0;
localparam [1:0] D_B0   = 2'h1;
localparam [1:0] D_B1   = 2'h2;
localparam [14:0] E_END = {K_END, C_ALL, A_REG, D_LIT, 8'h00};
localparam [14:0] E_RD  = {K_RD, C_ALL, A_REG, D_LIT, 8'h00};
localparam [14:0] E_POLL = {K_POLL, C_ALL, A_REG, D_LIT, 8'h00};
localparam [3:0] RECOVER_CYC = `FLASH_RECOVER_CYC;

function [14:0] step_entry;
    input [3:0] op;
    input [3:0] st;
    begin
        case ({op, st})
            {`FLASH_OP_READ_ARRAY, 4'h0}: step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_READ_ARRAY};
            {`FLASH_OP_READ_ARRAY, 4'h1}: step_entry = E_RD;
            {`FLASH_OP_READ_ID, 4'h0}:    step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_READ_ID};
            {`FLASH_OP_READ_ID, 4'h1}:    step_entry = E_RD;
            {`FLASH_OP_READ_STAT, 4'h0}:  step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_READ_STAT};
            {`FLASH_OP_READ_STAT, 4'h1}:  step_entry = E_RD;
            {`FLASH_OP_CLEAR_STAT, 4'h0}: step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_CLEAR_STAT};
            {`FLASH_OP_PROGRAM, 4'h0}:    step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROGRAM};
            {`FLASH_OP_PROGRAM, 4'h1}:    step_entry = {K_WR, C_ALL, A_REG, D_B0, 8'h00};
            {`FLASH_OP_PROGRAM, 4'h2}:    step_entry = E_POLL;
            {`FLASH_OP_PROGRAM2, 4'h0}:   step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROGRAM2};
            {`FLASH_OP_PROGRAM2, 4'h1}:   step_entry = {K_WR, C_ALL, A_REG, D_B0, 8'h00};
            {`FLASH_OP_PROGRAM2, 4'h2}:   step_entry = E_POLL;
            {`FLASH_OP_ERASE, 4'h0}:      step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_ERASE};
            {`FLASH_OP_ERASE, 4'h1}:      step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_ERASE, 4'h2}:      step_entry = E_POLL;
            {`FLASH_OP_ERASE, 4'h3}:      step_entry = {K_WR, C_DEF, A_REG, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_SUSPEND, 4'h0}:    step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_SUSPEND};
            {`FLASH_OP_SUSPEND, 4'h1}:    step_entry = E_POLL;
            {`FLASH_OP_RESUME, 4'h0}:     step_entry = {K_WR, C_NDEF, A_REG, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_PROT_SET, 4'h0}:   step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROT_SET};
            {`FLASH_OP_PROT_SET, 4'h1}:   step_entry = {K_WR, C_ALL, A_PROT, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_PROT_SET, 4'h2}:   step_entry = E_POLL;
            {`FLASH_OP_PROT_RESET, 4'h0}: step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROT_RESET};
            {`FLASH_OP_PROT_RESET, 4'h1}: step_entry = {K_WR, C_ALL, A_PROT, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_PROT_RESET, 4'h2}: step_entry = E_POLL;
            {`FLASH_OP_LOCK, 4'h0}:       step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROT_RESET};
            {`FLASH_OP_LOCK, 4'h1}:       step_entry = {K_WR, C_ALL, A_PROT, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_LOCK, 4'h2}:       step_entry = E_POLL;
            {`FLASH_OP_LOCK, 4'h3}:       step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_LOCK};
            {`FLASH_OP_LOCK, 4'h4}:       step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_LOCK, 4'h5}:       step_entry = E_POLL;
            {`FLASH_OP_LOCK, 4'h6}:       step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_PROT_SET};
            {`FLASH_OP_LOCK, 4'h7}:       step_entry = {K_WR, C_ALL, A_PROT, D_LIT, `FLASH_CMD_CONFIRM};
            {`FLASH_OP_LOCK, 4'h8}:       step_entry = E_POLL;
            {`FLASH_OP_TWO_BYTE, 4'h0}:   step_entry = {K_WR, C_ALL, A_REG, D_LIT, `FLASH_CMD_TWO_BYTE};
            {`FLASH_OP_TWO_BYTE, 4'h1}:   step_entry = {K_WR, C_ALL, A_REG, D_B0, 8'h00};
            {`FLASH_OP_TWO_BYTE, 4'h2}:   step_entry = {K_WR, C_ALL, A_REG, D_B1, 8'h00};
            {`FLASH_OP_TWO_BYTE, 4'h3}:   step_entry = E_POLL;
            default:                      step_entry = E_END;
        endcase
    end
endfunction

reg  [1:0]    seq_state;
reg  [3:0]    op;
reg  [3:0]    step;
reg           cyc_start;
reg           cyc_write;
reg  [AW-1:0] cyc_addr;
reg  [7:0]    cyc_data;
reg  [7:0]    status;
reg  [7:0]    read_byte;
reg           deferred;
reg           locks_loaded;
reg           refused;
reg  [3:0]    recover_cnt;
reg           pd;
reg  [AW-1:0] addr;
reg  [15:0]   wdata;
reg  [31:0]   rd_mux;
wire [7:0]    cyc_rdata;
wire          cyc_done;
wire [31:0]   be_mask;

wire [14:0] ent      = step_entry(op, step);
wire [1:0]  e_kind   = ent[14:13];
wire [1:0]  e_cond   = ent[12:11];
wire        e_asel   = ent[10];
wire [1:0]  e_dsel   = ent[9:8];
wire [7:0]  e_lit    = ent[7:0];
wire        cond_ok  = (e_cond == C_ALL) | ((e_cond == C_DEF) & deferred) | ((e_cond == C_NDEF) & ~deferred);
wire        busy     = (seq_state != S_IDLE) | pd | (recover_cnt != 4'h0);
wire        wr_take  = i_en & i_write & ~o_waitrequest;
wire        op_go    = wr_take & (i_address == `FLASH_OFF_CMD) & i_byteenable[0];
wire [AW-1:0] prot_addr = {{(AW-10){1'b0}}, `FLASH_PROTECT_ADDR};
wire [7:0]  masked_rd = cyc_rdata & `FLASH_ST_MASK;
wire [31:0] addr_merged = ({{(32-AW){1'b0}}, addr} & ~be_mask) | (i_writedata & be_mask);
wire [31:0] wdata_merged = ({16'h0000, wdata} & ~be_mask) | (i_writedata & be_mask);

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
        assign be_mask[g*8 +: 8] = {8{i_byteenable[g]}};
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// avalon slave: every access answers one cycle after it is presented
always @* begin
    case (i_address)
        `FLASH_OFF_CMD:    rd_mux = {28'h0000000, op};
        `FLASH_OFF_ADDR:   rd_mux = {{(32-AW){1'b0}}, addr};
        `FLASH_OFF_WDATA:  rd_mux = {16'h0000, wdata};
        `FLASH_OFF_STATUS: rd_mux = {10'h000, refused, (status[4] & status[5]), deferred, locks_loaded,
                                     i_ready_busy_pin, busy, read_byte, status};
        `FLASH_OFF_PD:     rd_mux = {31'h00000000, pd};
        default:           rd_mux = 32'h00000000;
    endcase
end

always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_waitrequest <= 1'b1;
        o_readdata    <= 32'h00000000;
        addr          <= {AW{1'b0}};
        wdata         <= 16'h0000;
        pd            <= 1'b0;
    end else if (i_en) begin
        if (!o_waitrequest) begin
            o_waitrequest <= 1'b1;
        end else if (i_read | i_write) begin
            o_waitrequest <= 1'b0;
            o_readdata    <= i_read ? rd_mux : 32'h00000000;
        end
        if (wr_take && i_address == `FLASH_OFF_ADDR) begin
            addr <= addr_merged[AW-1:0];
        end
        if (wr_take && i_address == `FLASH_OFF_WDATA) begin
            wdata <= wdata_merged[15:0];
        end
        if (wr_take && i_address == `FLASH_OFF_PD && i_byteenable[0]) begin
            pd <= i_writedata[0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// operation sequencer: walks the step table, one bus cycle per issued step; poll steps repeat until ready
always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        seq_state          <= S_IDLE;
        op                 <= `FLASH_OP_READ_ARRAY;
        step               <= 4'h0;
        cyc_start          <= 1'b0;
        cyc_write          <= 1'b0;
        cyc_addr           <= {AW{1'b0}};
        cyc_data           <= 8'h00;
        status             <= 8'h00;
        read_byte          <= 8'h00;
        deferred           <= 1'b0;
        locks_loaded       <= 1'b0;
        refused            <= 1'b0;
        recover_cnt        <= 4'h0;
        o_power_down_pin_n <= 1'b1;
    end else if (i_en) begin
        o_power_down_pin_n <= ~pd;
        if (op_go) begin
            refused <= busy;
        end
        if (pd) begin
            // device aborts and forgets everything while held down; mirror that here
            seq_state    <= S_IDLE;
            cyc_start    <= 1'b0;
            status       <= 8'h00;
            deferred     <= 1'b0;
            locks_loaded <= 1'b0;
            recover_cnt  <= RECOVER_CYC;
        end else begin
            if (recover_cnt != 4'h0) begin
                recover_cnt <= recover_cnt - 4'h1;
            end
            case (seq_state)
                S_IDLE: begin
                    if (op_go && !busy) begin
                        op        <= i_writedata[3:0];
                        step      <= 4'h0;
                        seq_state <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    if (e_kind == K_END) begin
                        seq_state <= S_IDLE;
                        if (op == `FLASH_OP_PROT_SET || op == `FLASH_OP_LOCK) begin
                            locks_loaded <= 1'b1;
                        end else if (op == `FLASH_OP_PROT_RESET) begin
                            locks_loaded <= 1'b0;
                        end
                    end else if (!cond_ok) begin
                        step <= step + 4'h1;
                    end else begin
                        cyc_start <= 1'b1;
                        cyc_write <= (e_kind == K_WR);
                        cyc_addr  <= (e_asel == A_PROT) ? prot_addr : addr;
                        cyc_data  <= (e_dsel == D_B0) ? wdata[7:0] : (e_dsel == D_B1) ? wdata[15:8] : e_lit;
                        if (e_cond == C_DEF) begin
                            deferred <= 1'b0;
                        end
                        seq_state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    cyc_start <= 1'b0;
                    if (cyc_done) begin
                        seq_state <= S_ISSUE;
                        if (e_kind == K_POLL) begin
                            // keep polling until ready; result bits mean nothing before that
                            if (cyc_rdata[`FLASH_ST_READY]) begin
                                status <= masked_rd;
                                step   <= step + 4'h1;
                                if (op == `FLASH_OP_SUSPEND && !cyc_rdata[`FLASH_ST_SUSPEND]) begin
                                    deferred <= 1'b1;
                                end
                            end
                        end else begin
                            step <= step + 4'h1;
                            if (e_kind == K_RD) begin
                                read_byte <= cyc_rdata;
                                if (op == `FLASH_OP_READ_STAT) begin
                                    status <= masked_rd;
                                end
                            end else if (op == `FLASH_OP_CLEAR_STAT) begin
                                status <= status & ~`FLASH_ST_CLEARABLE;
                            end
                        end
                    end
                end
                default: seq_state <= S_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
flash_bus_cycle #(
    .AW        (AW),
    .STROBE_RD (`FLASH_ACC_CYC),
    .STROBE_WR (`FLASH_WP_CYC)
) u_cycle (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_en     (i_en),
    .i_abort  (pd),
    .i_start  (cyc_start),
    .i_write  (cyc_write),
    .i_addr   (cyc_addr),
    .i_data   (cyc_data),
    .i_dq_in  (i_flash_dq_in),
    .o_addr   (o_flash_addr),
    .o_dq_out (o_flash_dq_out),
    .o_dq_oe  (o_flash_dq_oe),
    .o_ce_n   (o_flash_ce_n),
    .o_oe_n   (o_flash_oe_n),
    .o_we_n   (o_flash_we_n),
    .o_rdata  (cyc_rdata),
    .o_done   (cyc_done)
);

endmodule // flash_cui_host
`default_nettype wire

/* flash_cui_regs.vh */
// constants for the flash command host: register offsets, status fields, command codes,
// operation codes and bus timing. assumes a 20 MHz system clock.
`ifndef FLASH_CUI_REGS_VH
`define FLASH_CUI_REGS_VH

// avalon register byte offsets
`define FLASH_OFF_CMD        5'h00
`define FLASH_OFF_ADDR       5'h04
`define FLASH_OFF_WDATA      5'h08
`define FLASH_OFF_STATUS     5'h0C
`define FLASH_OFF_PD         5'h10

// device command codes
`define FLASH_CMD_READ_ARRAY 8'hFF
`define FLASH_CMD_READ_ID    8'h90
`define FLASH_CMD_READ_STAT  8'h70
`define FLASH_CMD_CLEAR_STAT 8'h50
`define FLASH_CMD_PROGRAM    8'h40
`define FLASH_CMD_PROGRAM2   8'h10
`define FLASH_CMD_ERASE      8'h20
`define FLASH_CMD_CONFIRM    8'hD0
`define FLASH_CMD_SUSPEND    8'hB0
`define FLASH_CMD_PROT_SET   8'h57
`define FLASH_CMD_PROT_RESET 8'h47
`define FLASH_CMD_LOCK       8'h77
`define FLASH_CMD_TWO_BYTE   8'hFB

// confirm address of protect set/reset: a9..a8 zero, a7..a0 ones
`define FLASH_PROTECT_ADDR   10'h0FF

// compat_status_reg fields
`define FLASH_ST_READY       7
`define FLASH_ST_SUSPEND     6
`define FLASH_ST_ERASE_FAIL  5
`define FLASH_ST_PROG_FAIL   4
`define FLASH_ST_SUPPLY_LOW  3
`define FLASH_ST_MASK        8'hF8
`define FLASH_ST_CLEARABLE   8'h38

// host operation codes, written to the command register
`define FLASH_OP_READ_ARRAY  4'h0
`define FLASH_OP_READ_ID     4'h1
`define FLASH_OP_READ_STAT   4'h2
`define FLASH_OP_CLEAR_STAT  4'h3
`define FLASH_OP_PROGRAM     4'h4
`define FLASH_OP_ERASE       4'h5
`define FLASH_OP_SUSPEND     4'h6
`define FLASH_OP_RESUME      4'h7
`define FLASH_OP_PROT_SET    4'h8
`define FLASH_OP_PROT_RESET  4'h9
`define FLASH_OP_LOCK        4'hA
`define FLASH_OP_TWO_BYTE    4'hB
`define FLASH_OP_PROGRAM2    4'hC

// whole 50 ns cycles: 100 ns access, 100 ns write pulse, 550 ns power-down recovery
`define FLASH_ACC_CYC        4'h2
`define FLASH_WP_CYC         4'h2
`define FLASH_RECOVER_CYC    4'hB

`endif

/* flash_bus_cycle.v */
// one asynchronous flash bus cycle (read or write) on the parallel pins.
// assumes the data pins are synchronous to i_clk; strobe widths are whole clock cycles.
`timescale 1ns/1ps
`default_nettype none

module flash_bus_cycle #(
    parameter AW        = 19,
    parameter STROBE_RD = 2,
    parameter STROBE_WR = 2
) (
    input  wire          i_clk,
    input  wire          i_arst_n,
    input  wire          i_en,
    input  wire          i_abort,
    input  wire          i_start,
    input  wire          i_write,
    input  wire [AW-1:0] i_addr,
    input  wire [7:0]    i_data,
    input  wire [7:0]    i_dq_in,
    output reg  [AW-1:0] o_addr,
    output reg  [7:0]    o_dq_out,
    output reg           o_dq_oe,
    output reg           o_ce_n,
    output reg           o_oe_n,
    output reg           o_we_n,
    output reg  [7:0]    o_rdata,
    output reg           o_done
);

localparam [1:0] S_IDLE   = 2'h0;
localparam [1:0] S_SETUP  = 2'h1;
localparam [1:0] S_STROBE = 2'h2;
localparam [1:0] S_HOLD   = 2'h3;
localparam [3:0] RD_LAST  = STROBE_RD - 1;
localparam [3:0] WR_LAST  = STROBE_WR - 1;

reg [1:0] state;
reg [3:0] cnt;
reg       is_wr;

////////////////////////////////////////////////////////////////////////////////
// address and data are set up one cycle before the strobe and held one after,
// so the device never sees them move while we_n or oe_n is low
always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        state    <= S_IDLE;
        cnt      <= 4'h0;
        is_wr    <= 1'b0;
        o_addr   <= {AW{1'b0}};
        o_dq_out <= 8'h00;
        o_dq_oe  <= 1'b0;
        o_ce_n   <= 1'b1;
        o_oe_n   <= 1'b1;
        o_we_n   <= 1'b1;
        o_rdata  <= 8'h00;
        o_done   <= 1'b0;
    end else if (i_en) begin
        o_done <= 1'b0;
        if (i_abort) begin
            state   <= S_IDLE;
            o_ce_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            o_we_n  <= 1'b1;
            o_dq_oe <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (i_start) begin
                        o_addr   <= i_addr;
                        o_dq_out <= i_data;
                        o_dq_oe  <= i_write;
                        is_wr    <= i_write;
                        o_ce_n   <= 1'b0;
                        state    <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    o_we_n <= ~is_wr;
                    o_oe_n <= is_wr;
                    cnt    <= is_wr ? WR_LAST : RD_LAST;
                    state  <= S_STROBE;
                end
                S_STROBE: begin
                    if (cnt == 4'h0) begin
                        o_we_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        if (!is_wr) begin
                            o_rdata <= i_dq_in;
                        end
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_HOLD: begin
                    o_ce_n  <= 1'b1;
                    o_dq_oe <= 1'b0;
                    o_done  <= 1'b1;
                    state   <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

endmodule // flash_bus_cycle
`default_nettype wire

/* flash_cui_host_sva.sv */
// pin and bus-handshake checker for the flash command host
// assumes i_en stays high while watched
`timescale 1ns/1ps
`default_nettype none
module flash_cui_host_sva (
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire logic       o_waitrequest,
    input wire logic       o_flash_ce_n,
    input wire logic       o_flash_oe_n,
    input wire logic       o_flash_we_n,
    input wire logic       o_flash_dq_oe,
    input wire logic [7:0] o_flash_dq_out,
    input wire logic       o_power_down_pin_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    AST_RD: assert property (!o_flash_oe_n |-> !o_flash_ce_n && o_flash_we_n && !o_flash_dq_oe)
        else $error("read strobe with bad qualifiers");
    AST_WR: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe)
        else $error("write strobe without data drive");
    AST_WIDTH: assert property ($fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n)
        else $error("write strobe not two cycles");
    AST_DATA: assert property (!o_flash_we_n && !$fell(o_flash_we_n) |-> $stable(o_flash_dq_out))
        else $error("data moved under write strobe");
    AST_SETUP: assert property ($fell(o_flash_ce_n) |-> o_flash_we_n && o_flash_oe_n)
        else $error("strobe in setup cycle");
    AST_GAP: assert property ($rose(o_flash_ce_n) |-> o_flash_ce_n [*2])
        else $error("idle gap too short");
    AST_ACK: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low too long");
    AST_PD: assert property (!o_power_down_pin_n |-> o_flash_we_n && o_flash_oe_n)
        else $error("strobe during power-down");
endmodule // flash_cui_host_sva
bind flash_cui_host flash_cui_host_sva u_sva (.*);
`default_nettype wire

/* flash_dev_model.sv */
// flash device model: command decoder, block locks and status byte
// assumes pins change on i_clk; ready output already resolved with its pull-up
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(parameter MAN = 8'hA5, DEV = 8'h3C, BUSY = 30) ( // id values arbitrary
    input  wire logic        i_clk,
    input  wire logic [18:0] i_addr,
    input  wire logic [7:0]  i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_pd_n,
    output wire logic [7:0]  o_dq,
    output wire logic        o_ready
);
    logic [7:0]  mem [0:255];
    logic [7:0]  nxt, cnt, last;
    logic [5:3]  st;
    logic [31:0] lk;
    logic [1:0]  mode;
    logic        we_q, susp, ld, unl;
    wire         rdy = cnt == 8'h00 || susp;
    wire         lok = !ld || (!unl && lk[i_addr[18:14]]);
    wire [7:0]   compat_status_reg = {rdy, susp, st, 3'h0};
    wire [7:0]   rd = mode == 2'h2 ? compat_status_reg : mode == 2'h1 ? (i_addr[0] ? DEV : MAN) : mem[i_addr[7:0]];
    // released bus shows a changing pattern, never the last value
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
    assign o_ready = rdy;
    initial {st, cnt, mode, susp, ld, unl, nxt, lk, last, we_q} = 1'h1;
    always @(posedge i_clk or negedge i_pd_n) begin
        if (!i_pd_n) begin
            {st, cnt, mode, susp, ld, unl, nxt} <= '0;
        end else begin
            we_q <= i_we_n;
            last <= o_dq;
            if (cnt != 8'h00 && !susp) cnt <= cnt - 8'h01;
            if (!we_q && i_we_n) begin
                nxt <= 8'h00;
                if (nxt == 8'h40 || nxt == 8'h10 || nxt == 8'hFC) begin
                    mode <= 2'h2;
                    if (lok) st[4] <= 1'h1;
                    else begin mem[i_addr[7:0] ^ {7'h00, nxt[2]}] <= i_dq; cnt <= BUSY; end
                end else if (nxt == 8'h20) begin
                    mode <= 2'h2;
                    if (i_dq != 8'hD0) st[5:4] <= 2'h3;
                    else if (lok) st[5] <= 1'h1;
                    else cnt <= BUSY;
                end else if (nxt == 8'h57 || nxt == 8'h47 || nxt == 8'h77) begin
                    mode <= 2'h2;
                    if (i_dq == 8'hD0 && nxt[5]) lk[i_addr[18:14]] <= 1'h1;
                    else if (i_dq == 8'hD0 && i_addr[9:0] == 10'h0FF) {ld, unl} <= {1'h1, !nxt[4]};
                end else if (nxt == 8'hFB) begin
                    if (!lok) mem[i_addr[7:0]] <= i_dq;
                    nxt <= 8'hFC;
                end else if (!rdy) begin
                    if (i_dq == 8'hB0) susp <= 1'h1;
                end else case (i_dq)
                    8'hFF: mode <= 2'h0;
                    8'h90: mode <= 2'h1;
                    8'h70: mode <= 2'h2;
                    8'h50: st <= 3'h0;
                    8'hD0: susp <= 1'h0;
                    default: nxt <= i_dq;
                endcase
            end
        end
    end
endmodule // flash_dev_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench: flash command host driving the device model
// assumes one-cycle avalon answer; i_en and byte lanes held on
`timescale 1ns/1ps
`default_nettype none
`include "flash_cui_regs.vh"
module tb_top;
    logic        i_clk = 1'h0, i_arst_n = 1'h0, i_read = 1'h0, i_write = 1'h0;
    logic [4:0]  i_address = 5'h00;
    logic [31:0] i_writedata = 32'h0, o_readdata, rv;
    logic        o_waitrequest, dq_oe, ce_n, oe_n, we_n, pd_n, ready;
    logic [18:0] fa;
    logic [7:0]  dq_out, dq_dev;
    int          errors = 0, comparisons = 0;
    initial forever #25 i_clk = ~i_clk;
    flash_cui_host DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_en(1'h1), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_flash_addr(fa), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe),
        .i_flash_dq_in(dq_oe ? dq_out : dq_dev), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
        .o_flash_we_n(we_n), .o_power_down_pin_n(pd_n), .i_ready_busy_pin(ready));
    flash_dev_model MODEL (.i_clk(i_clk), .i_addr(fa), .i_dq(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .i_pd_n(pd_n), .o_dq(dq_dev), .o_ready(ready));
    ////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        do begin @(posedge i_clk); n++; end while (o_waitrequest !== 1'h0 && n < 50);
        if (n >= 50) begin errors++; report_and_stop; end
        rv = o_readdata;
        i_read <= 1'h0;
        i_write <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic idle;
        int n;
        n = 0;
        do begin bus(1'h0, `FLASH_OFF_STATUS, 32'h0); n++; end while (rv[16] !== 1'h0 && n < 400);
        if (n >= 400) begin errors++; report_and_stop; end
    endtask
    task automatic op(input logic [3:0] c, input logic [18:0] a);
        idle;
        bus(1'h1, `FLASH_OFF_ADDR, {13'h0, a});
        bus(1'h1, `FLASH_OFF_CMD, {28'h0, c});
        idle;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'h1;
        @(posedge i_clk);
        bus(1'h1, `FLASH_OFF_WDATA, 32'hC35A);
        op(`FLASH_OP_PROGRAM, 19'h04005);
        chk(rv[7:0], 8'h90);
        op(`FLASH_OP_CLEAR_STAT, 19'h0);
        op(`FLASH_OP_READ_STAT, 19'h0);
        chk(rv[7:0], 8'h80);
        op(`FLASH_OP_PROT_SET, 19'h0);
        op(`FLASH_OP_PROGRAM2, 19'h04005);
        chk(rv[7:0], 8'h80);
        op(`FLASH_OP_TWO_BYTE, 19'h04010);
        op(`FLASH_OP_READ_ARRAY, 19'h04011);
        chk(rv[15:8], 8'hC3);
        op(`FLASH_OP_ERASE, 19'h08000);
        chk(rv[7:0], 8'h80);
        op(`FLASH_OP_SUSPEND, 19'h0);
        chk(rv[19], 1'h1);
        op(`FLASH_OP_ERASE, 19'h08000);
        chk(rv[19], 1'h0);
        bus(1'h1, `FLASH_OFF_CMD, `FLASH_OP_ERASE);
        bus(1'h1, `FLASH_OFF_CMD, `FLASH_OP_READ_STAT);
        bus(1'h0, `FLASH_OFF_STATUS, 32'h0);
        chk(rv[21], 1'h1);
        op(`FLASH_OP_READ_ARRAY, 19'h04005);
        chk(rv[15:8], 8'h5A);
        op(`FLASH_OP_READ_ID, 19'h0);
        chk(rv[15:8], 8'hA5);
        op(`FLASH_OP_READ_ID, 19'h1);
        chk(rv[15:8], 8'h3C);
        op(`FLASH_OP_LOCK, 19'h08000);
        op(`FLASH_OP_PROGRAM, 19'h08001);
        chk(rv[7:0], 8'h90);
        op(`FLASH_OP_CLEAR_STAT, 19'h0);
        op(`FLASH_OP_PROT_RESET, 19'h0);
        op(`FLASH_OP_PROGRAM, 19'h08001);
        chk(rv[7:0], 8'h80);
        bus(1'h1, `FLASH_OFF_PD, 32'h1);
        bus(1'h0, `FLASH_OFF_STATUS, 32'h0);
        chk({rv[18:16], rv[7:0]}, 11'h300);
        bus(1'h1, `FLASH_OFF_PD, 32'h0);
        op(`FLASH_OP_PROGRAM, 19'h04005);
        chk(rv[7:0], 8'h90);
        bus(1'h0, 5'h14, 32'h0);
        chk(rv, 32'h0);
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
